// ===== plc_mbx_pkg.sv
// Constants, codes and states of the CPU command mailbox
package plc_mbx_pkg;

  // Clock rate and derived cycle counts
  localparam int CLK_HZ      = 20_000_000;    // System clock, 50 ns period
  localparam int SEC_MS      = 1000;          // One calendar second in ms
  localparam int SEC_CYC     = CLK_HZ / 1000 * SEC_MS;
  localparam int BLINK_MS    = 500;           // Run indicator half period in ms
  localparam int BLINK_CYC   = CLK_HZ / 1000 * BLINK_MS;
  localparam int REFRESH_MIN = 10;            // Calendar refresh interval in minutes
  localparam int REFRESH_S   = REFRESH_MIN * 60;
  localparam int RESTART_CYC = 16;            // Restart pulse length in cycles
  localparam int FACTORY_CYC = 64;            // Factory restore length in cycles
  localparam int MAX_CONN    = 8;             // TCP slots in server mode

  // Data register numbers of the shared area
  localparam logic [15:0] REG_FIRST = 16'h0F6E;
  localparam logic [15:0] REG_LAST  = 16'h0F9F;
  localparam logic [5:0] IDX_CMD   = 6'h00;   // Command code
  localparam logic [5:0] IDX_PROG  = 6'h01;   // Callback progress
  localparam logic [5:0] IDX_DST   = 6'h02;   // Daylight selector
  localparam logic [5:0] IDX_SEC   = 6'h03;
  localparam logic [5:0] IDX_MIN   = 6'h04;
  localparam logic [5:0] IDX_HOUR  = 6'h05;
  localparam logic [5:0] IDX_DAY   = 6'h06;
  localparam logic [5:0] IDX_UPD   = 6'h0A;   // Refresh counter

  // Command codes
  localparam logic [15:0] CMD_NONE     = 16'h0000;
  localparam logic [15:0] CMD_CALLBACK = 16'h3359;
  localparam logic [15:0] CMD_RESTART  = 16'h3450;
  localparam logic [15:0] CMD_FACTORY  = 16'h3451;

  // Progress codes
  localparam logic [15:0] PR_STANDBY = 16'h0000;
  localparam logic [15:0] PR_CONNING = 16'h0001;
  localparam logic [15:0] PR_UP      = 16'h0002;
  localparam logic [15:0] PR_FAILED  = 16'h0005;
  localparam logic [15:0] PR_REFUSED = 16'h0006;
  localparam logic [15:0] PR_CERT    = 16'h0007;
  localparam logic [15:0] PR_ENDED   = 16'h0008;

  // Reset values
  localparam logic [15:0] DAY_RST = 16'h0001;

  // Callback sequence
  typedef enum logic [2:0] {
    CB_IDLE, CB_CONNING, CB_CERT, CB_UP, CB_FAILED, CB_REFUSED, CB_ENDED
  } cb_state_e;

endpackage : plc_mbx_pkg

// ===== plc_module_command_mailbox.sv
// Command mailbox, calendar, indicators and connection slots of the board
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - All exchange goes through shared data registers
// - Callback code starts call, zero ends it
// - Restart code restarts module, then clears command
// - Factory code restores defaults, then clears command
// - Refresh every ten minutes, bump counter
// - Error indicator lit on port 3 baud failure
// - Run blinks, power steady, per-port activity
// - Boot jumper at power-up selects bootloader
// - Bypass jumper disables password protection
// - At most eight TCP connections in server
// - Proprietary client mode disables Modbus functions
// - Mode 0 CPU traffic uses no slots
module plc_module_command_mailbox #(
  parameter int SEC_CYC   = plc_mbx_pkg::SEC_CYC,
  parameter int BLINK_CYC = plc_mbx_pkg::BLINK_CYC,
  parameter int MAX_CONN  = plc_mbx_pkg::MAX_CONN
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] reg_addr,          // Data register number
  input  wire logic        reg_wr,            // CPU write strobe
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_ff,      // Read data, one cycle later
  output logic             callback_run_ff,   // Outbound call wanted
  input  wire logic        cb_cert,           // Stack: certificating
  input  wire logic        cb_up,             // Stack: connected
  input  wire logic        cb_fail,           // Stack: connection failed
  input  wire logic        cb_refuse,         // Stack: connection refused
  output logic             module_restart_ff, // Soft restart in progress
  output logic             factory_restore_ff,// Default restore in progress
  output logic             ntp_req_ff,        // Pulse: ask for time sync
  input  wire logic        ntp_valid,         // Pulse: fresh time below
  input  wire logic [5:0]  ntp_sec,
  input  wire logic [5:0]  ntp_min,
  input  wire logic [4:0]  ntp_hour,
  input  wire logic [4:0]  ntp_day,
  input  wire logic        baud_fail_p3,      // Port 3 baud detection failed
  input  wire logic        act_p3,            // Port 3 traffic
  input  wire logic        act_p4,            // Port 4 traffic
  output logic             led_power_ff,
  output logic             led_run_ff,
  output logic             led_err_ff,
  output logic             led_p3_ff,
  output logic             led_p4_ff,
  input  wire logic        boot_jumper,
  input  wire logic        password_bypass_jumper,
  output logic             boot_mode_ff,
  output logic             pw_bypass_ff,
  input  wire logic        server_mode,
  input  wire logic        conn_open,         // Pulse: TCP open request
  input  wire logic        conn_close,        // Pulse: TCP slot released
  input  wire logic        conn_mode0,        // Request is CPU mode 0 traffic
  output logic             conn_accept_ff,
  output logic             conn_reject_ff,
  output logic      [3:0]  conn_count_ff,
  input  wire logic        prop_client_mode,  // Proprietary client selected
  input  wire logic        mb_server_cfg,
  input  wire logic        mb_client_cfg,
  output logic             mb_server_en_ff,
  output logic             mb_client_en_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Wrapping increment used by every calendar field
  function automatic logic [5:0] wrap_inc(input logic [5:0] v,
                                          input logic [5:0] top,
                                          input logic [5:0] bot);
    wrap_inc = (v >= top) ? bot : 6'(v + 6'h01);
  endfunction : wrap_inc

  // State to progress code
  function automatic logic [15:0] prog_code(input plc_mbx_pkg::cb_state_e s);
    unique case (s)
      plc_mbx_pkg::CB_IDLE:    prog_code = plc_mbx_pkg::PR_STANDBY;
      plc_mbx_pkg::CB_CONNING: prog_code = plc_mbx_pkg::PR_CONNING;
      plc_mbx_pkg::CB_CERT:    prog_code = plc_mbx_pkg::PR_CERT;
      plc_mbx_pkg::CB_UP:      prog_code = plc_mbx_pkg::PR_UP;
      plc_mbx_pkg::CB_FAILED:  prog_code = plc_mbx_pkg::PR_FAILED;
      plc_mbx_pkg::CB_REFUSED: prog_code = plc_mbx_pkg::PR_REFUSED;
      plc_mbx_pkg::CB_ENDED:   prog_code = plc_mbx_pkg::PR_ENDED;
      default:                 prog_code = plc_mbx_pkg::PR_STANDBY;
    endcase
  endfunction : prog_code

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic [15:0] cmd_ff;         // Command code register
  logic        dst_ff;         // Daylight selector, bit 0 only
  logic [15:0] upd_cnt_ff;     // Refresh counter
  logic [5:0]  sec_ff, min_ff; // Running calendar, standard time
  logic [4:0]  hour_ff, day_ff;
  logic [7:0]  busy_cnt_ff;    // Restart / restore progress
  plc_mbx_pkg::cb_state_e cb_st_ff, nxt_cb_st;

  wire         in_area = (reg_addr >= plc_mbx_pkg::REG_FIRST) &&
                         (reg_addr <= plc_mbx_pkg::REG_LAST);
  wire [15:0]  off16   = reg_addr - plc_mbx_pkg::REG_FIRST;
  wire [5:0]   idx     = off16[5:0];
  wire         cmd_wr  = reg_wr && in_area && (idx == plc_mbx_pkg::IDX_CMD);
  wire         dst_wr  = reg_wr && in_area && (idx == plc_mbx_pkg::IDX_DST);

  // Daylight applied only to the published hour; the day does not carry
  // on the shifted midnight, a known limitation of this simple view
  wire [4:0]   pub_hour = (dst_ff && hour_ff == 5'd23) ? 5'd0 :
                          5'(hour_ff + {4'd0, dst_ff});

  logic [15:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 16'h0000;  // Unused words of the area read zero
    if (in_area)
    begin
      unique case (idx)
        plc_mbx_pkg::IDX_CMD:  nxt_rdata = cmd_ff;
        plc_mbx_pkg::IDX_PROG: nxt_rdata = prog_code(cb_st_ff);
        plc_mbx_pkg::IDX_DST:  nxt_rdata = {15'd0, dst_ff};
        plc_mbx_pkg::IDX_SEC:  nxt_rdata = {10'd0, sec_ff};
        plc_mbx_pkg::IDX_MIN:  nxt_rdata = {10'd0, min_ff};
        plc_mbx_pkg::IDX_HOUR: nxt_rdata = {11'd0, pub_hour};
        plc_mbx_pkg::IDX_DAY:  nxt_rdata = {11'd0, day_ff};
        plc_mbx_pkg::IDX_UPD:  nxt_rdata = upd_cnt_ff;
        default:               nxt_rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command register and restart / restore sequencing

  wire busy     = module_restart_ff || factory_restore_ff;
  wire busy_end = busy && (busy_cnt_ff == 8'd1);
  wire go_rst   = cmd_wr && reg_wdata == plc_mbx_pkg::CMD_RESTART && !busy;
  wire go_fac   = cmd_wr && reg_wdata == plc_mbx_pkg::CMD_FACTORY && !busy;

  // A CPU write in the clearing cycle wins, so no new command is lost
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cmd_ff <= plc_mbx_pkg::CMD_NONE;
    else if (cmd_wr)
      cmd_ff <= reg_wdata;
    else if (busy_end)
      cmd_ff <= plc_mbx_pkg::CMD_NONE;
  end

  // Restart and restore hold their outputs for a fixed count
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      module_restart_ff  <= 1'b0;
      factory_restore_ff <= 1'b0;
      busy_cnt_ff        <= 8'd0;
    end
    else if (go_rst)
    begin
      module_restart_ff <= 1'b1;
      busy_cnt_ff       <= 8'(plc_mbx_pkg::RESTART_CYC);
    end
    else if (go_fac)
    begin
      factory_restore_ff <= 1'b1;
      busy_cnt_ff        <= 8'(plc_mbx_pkg::FACTORY_CYC);
    end
    else if (busy_end)
    begin
      module_restart_ff  <= 1'b0;
      factory_restore_ff <= 1'b0;
      busy_cnt_ff        <= 8'd0;
    end
    else if (busy)
      busy_cnt_ff <= 8'(busy_cnt_ff - 8'd1);
  end

  // Daylight selector, written by the CPU only
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      dst_ff <= 1'b0;
    else if (dst_wr)
      dst_ff <= reg_wdata[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Callback sequence

  wire cb_start = cmd_wr && reg_wdata == plc_mbx_pkg::CMD_CALLBACK;
  wire cb_stop  = cmd_wr && reg_wdata == plc_mbx_pkg::CMD_NONE;
  wire cb_live  = cb_st_ff inside {plc_mbx_pkg::CB_CONNING,
                                   plc_mbx_pkg::CB_CERT, plc_mbx_pkg::CB_UP};

  // Only a fresh write starts a call, so a failed call does not loop
  always_comb
  begin
    nxt_cb_st = cb_st_ff;
    if (cb_live && cb_stop)
      nxt_cb_st = plc_mbx_pkg::CB_ENDED;
    else if (!cb_live && cb_start)
      nxt_cb_st = plc_mbx_pkg::CB_CONNING;
    else if (cb_live && cb_fail)
      nxt_cb_st = plc_mbx_pkg::CB_FAILED;
    else if (cb_live && cb_refuse)
      nxt_cb_st = plc_mbx_pkg::CB_REFUSED;
    else if (cb_st_ff == plc_mbx_pkg::CB_CONNING && cb_cert)
      nxt_cb_st = plc_mbx_pkg::CB_CERT;
    else if (cb_st_ff == plc_mbx_pkg::CB_CERT && cb_up)
      nxt_cb_st = plc_mbx_pkg::CB_UP;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cb_st_ff        <= plc_mbx_pkg::CB_IDLE;
      callback_run_ff <= 1'b0;
    end
    else
    begin
      cb_st_ff        <= nxt_cb_st;
      callback_run_ff <= nxt_cb_st inside {plc_mbx_pkg::CB_CONNING,
                         plc_mbx_pkg::CB_CERT, plc_mbx_pkg::CB_UP};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calendar, seconds tick and ten-minute refresh

  logic [24:0] tick_cnt_ff;  // Cycles within one second
  logic [9:0]  refr_cnt_ff;  // Seconds since last refresh request
  wire         sec_tick = (tick_cnt_ff == 25'(SEC_CYC - 1));
  wire         refr_due = sec_tick &&
                          (refr_cnt_ff == 10'(plc_mbx_pkg::REFRESH_S - 1));
  wire [5:0]   n_sec  = wrap_inc(sec_ff, 6'd59, 6'd0);
  wire [5:0]   n_min  = wrap_inc(min_ff, 6'd59, 6'd0);
  wire [5:0]   n_hour = wrap_inc({1'b0, hour_ff}, 6'd23, 6'd0);
  wire [5:0]   n_day  = wrap_inc({1'b0, day_ff}, 6'd31, 6'd1);
  wire         c_min  = sec_ff == 6'd59;
  wire         c_hour = c_min && min_ff == 6'd59;
  wire         c_day  = c_hour && hour_ff == 5'd23;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_cnt_ff <= 25'd0;
      refr_cnt_ff <= 10'd0;
      ntp_req_ff  <= 1'b0;
    end
    else
    begin
      tick_cnt_ff <= sec_tick ? 25'd0 : 25'(tick_cnt_ff + 25'd1);
      ntp_req_ff  <= refr_due;
      if (sec_tick)
        refr_cnt_ff <= refr_due ? 10'd0 : 10'(refr_cnt_ff + 10'd1);
    end
  end

  // Sync loads the calendar and bumps the counter; otherwise it runs
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sec_ff     <= 6'd0;
      min_ff     <= 6'd0;
      hour_ff    <= 5'd0;
      day_ff     <= plc_mbx_pkg::DAY_RST[4:0];
      upd_cnt_ff <= 16'h0000;
    end
    else if (ntp_valid)
    begin
      sec_ff     <= ntp_sec;
      min_ff     <= ntp_min;
      hour_ff    <= ntp_hour;
      day_ff     <= ntp_day;
      upd_cnt_ff <= 16'(upd_cnt_ff + 16'h0001);
    end
    else if (sec_tick)
    begin
      sec_ff <= n_sec;
      if (c_min)
        min_ff <= n_min;
      if (c_hour)
        hour_ff <= n_hour[4:0];
      if (c_day)
        day_ff <= n_day[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicators, jumpers, slots and protocol enables

  logic [24:0] blink_cnt_ff;
  logic        boot_taken_ff;  // Boot jumper already sampled
  wire         blink_wrap = (blink_cnt_ff == 25'(BLINK_CYC - 1));
  wire         slot_req   = conn_open && !conn_mode0;
  wire         slot_full  = (conn_count_ff == 4'hF) ||                 // Count never wraps
                            (server_mode && conn_count_ff >= 4'(MAX_CONN));

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      blink_cnt_ff <= 25'd0;
      led_power_ff <= 1'b0;
      led_run_ff   <= 1'b0;
      led_err_ff   <= 1'b0;
      led_p3_ff    <= 1'b0;
      led_p4_ff    <= 1'b0;
    end
    else
    begin
      blink_cnt_ff <= blink_wrap ? 25'd0 : 25'(blink_cnt_ff + 25'd1);
      led_power_ff <= 1'b1;
      led_run_ff   <= blink_wrap ? !led_run_ff : led_run_ff;
      led_err_ff   <= baud_fail_p3;
      led_p3_ff    <= act_p3;
      led_p4_ff    <= act_p4;
    end
  end

  // Boot jumper is caught once after reset release, bypass follows it live
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      boot_taken_ff <= 1'b0;
      boot_mode_ff  <= 1'b0;
      pw_bypass_ff  <= 1'b0;
    end
    else
    begin
      boot_taken_ff <= 1'b1;
      if (!boot_taken_ff)
        boot_mode_ff <= boot_jumper;
      pw_bypass_ff <= password_bypass_jumper;
    end
  end

  // Slot accounting; a release in the same cycle as an open is netted
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      conn_count_ff   <= 4'd0;
      conn_accept_ff  <= 1'b0;
      conn_reject_ff  <= 1'b0;
      mb_server_en_ff <= 1'b0;
      mb_client_en_ff <= 1'b0;
    end
    else
    begin
      conn_accept_ff <= conn_open && (conn_mode0 || !slot_full);
      conn_reject_ff <= slot_req && slot_full;
      if (slot_req && !slot_full && !(conn_close && conn_count_ff != 4'd0))
        conn_count_ff <= 4'(conn_count_ff + 4'd1);
      else if (!(slot_req && !slot_full) && conn_close && conn_count_ff != 4'd0)
        conn_count_ff <= 4'(conn_count_ff - 4'd1);
      mb_server_en_ff <= mb_server_cfg && !prop_client_mode;
      mb_client_en_ff <= mb_client_cfg && !prop_client_mode;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata_ff <= 16'h0000;
    else
      reg_rdata_ff <= nxt_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb_chk @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_restart_clears: assert property (busy_end && !cmd_wr |=> cmd_ff == 16'h0000)
    else $error("command not cleared after restart or restore");
  a_restart_len: assert property ($rose(module_restart_ff) |->
    module_restart_ff [*8])
    else $error("restart output too short");
  a_factory_start: assert property (go_fac |=> factory_restore_ff)
    else $error("factory restore did not start");
  a_callback_start: assert property (!cb_live && cb_start |=> callback_run_ff
    ##0 prog_code(cb_st_ff) == 16'h0001)
    else $error("callback did not start");
  a_callback_end: assert property (cb_live && cb_stop |=> !callback_run_ff
    ##0 prog_code(cb_st_ff) == 16'h0008)
    else $error("callback did not end");
  a_update_count: assert property (ntp_valid |=> upd_cnt_ff ==
    16'($past(upd_cnt_ff) + 16'h0001))
    else $error("refresh counter not bumped");
  a_err_led: assert property (baud_fail_p3 |=> led_err_ff)
    else $error("error indicator not lit");
  a_slot_limit: assert property (server_mode |-> conn_count_ff <= 4'(MAX_CONN))
    else $error("too many connections");
  a_modbus_off: assert property (prop_client_mode |=>
    !mb_server_en_ff && !mb_client_en_ff)
    else $error("Modbus left enabled");
  a_boot_steady: assert property (boot_taken_ff |=> $stable(boot_mode_ff))
    else $error("boot mode changed after power-up");

  c_call_up: cover property (cb_st_ff == plc_mbx_pkg::CB_UP);
  c_restart: cover property (busy_end && module_restart_ff);
  c_sync: cover property (ntp_req_ff ##[1:20] ntp_valid);
  c_reject: cover property (conn_reject_ff);

endmodule : plc_module_command_mailbox

`default_nettype wire

// ===== plc_cpu_model.sv
// CPU side of the shared data register area
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module plc_cpu_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] reg_rdata_ff,
  output var  logic [15:0] reg_addr,
  output var  logic        reg_wr,
  output var  logic [15:0] reg_wdata
);
  // Idle bus at time zero: no strobe
  initial
  begin
    reg_addr  = 16'h0000;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
  end

  // One-cycle write strobe; data is inverted once released, so stale data never matches
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wr    <= 1'b1;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // Address held two edges, data taken once the registered answer has settled
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    d = reg_rdata_ff;
  endtask : rd
endmodule : plc_cpu_model
`default_nettype wire

// ===== plc_module_command_mailbox_tb.sv
// Self-checking bench of the command mailbox
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module plc_module_command_mailbox_tb;
  localparam logic [15:0] A0 = plc_mbx_pkg::REG_FIRST; // First word of the area
  logic        sys_clk;
  logic        rstn;
  logic [15:0] reg_addr, reg_wdata, reg_rdata_ff;
  logic        reg_wr;
  logic [6:0]  ev;        // Pulses: cert up fail refuse sync open close
  logic [9:0]  lv;        // Levels: baud act3 act4 boot bypass server mode0 prop mbs mbc
  logic [5:0]  t_sec, t_min;
  logic [4:0]  t_hour, t_day;
  logic        run, rst_o, fac_o, req_o, pwr, led_r, led_e, led_3, led_4;
  logic        boot_o, pw_o, acc, rej, mbs_o, mbc_o, r0;
  logic [3:0]  cnt;
  logic [15:0] d, c0;
  int          error_cnt, check_count, n, k;

  // Shortened second and blink counts keep the run short
  plc_module_command_mailbox #(.SEC_CYC(20), .BLINK_CYC(8), .MAX_CONN(8))
    i_plc_module_command_mailbox (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .callback_run_ff(run),
    .cb_cert(ev[0]), .cb_up(ev[1]), .cb_fail(ev[2]), .cb_refuse(ev[3]),
    .module_restart_ff(rst_o), .factory_restore_ff(fac_o), .ntp_req_ff(req_o),
    .ntp_valid(ev[4]), .ntp_sec(t_sec), .ntp_min(t_min), .ntp_hour(t_hour), .ntp_day(t_day),
    .baud_fail_p3(lv[0]), .act_p3(lv[1]), .act_p4(lv[2]), .led_power_ff(pwr),
    .led_run_ff(led_r), .led_err_ff(led_e), .led_p3_ff(led_3), .led_p4_ff(led_4),
    .boot_jumper(lv[3]), .password_bypass_jumper(lv[4]), .boot_mode_ff(boot_o),
    .pw_bypass_ff(pw_o), .server_mode(lv[5]), .conn_open(ev[5]), .conn_close(ev[6]),
    .conn_mode0(lv[6]), .conn_accept_ff(acc), .conn_reject_ff(rej), .conn_count_ff(cnt),
    .prop_client_mode(lv[7]), .mb_server_cfg(lv[8]), .mb_client_cfg(lv[9]),
    .mb_server_en_ff(mbs_o), .mb_client_en_ff(mbc_o));

  // CPU partner drives the register port
  plc_cpu_model i_plc_cpu_model (
    .sys_clk(sys_clk), .reg_rdata_ff(reg_rdata_ff), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata));

  ////////////////////////////////////////////////////////////////////////////////
  // 50 ns clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Totals and verdict, the single end of the run
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // A used-up wait bound counts as a mismatch and ends the run
  task automatic tmo(input int cnt_n, input int lim);
    if (cnt_n >= lim)
    begin
      chk(16'(cnt_n), 16'(lim - 1));
      report_and_stop();
    end
  endtask : tmo

  // One-cycle pulse on the stack side, then wait for the registered reply
  task automatic pulse(input logic [6:0] m);
    @(posedge sys_clk) ev <= m;
    @(posedge sys_clk) ev <= 7'h00;
    @(negedge sys_clk);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    error_cnt = 0;
    check_count = 0;
    ev = 7'h00;
    lv = 10'h008;                                  // Boot jumper shorted at power-up
    {t_sec, t_min, t_hour, t_day} = 22'h0;
    rstn = 1'b0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(pwr, 1'b1);
    chk(boot_o, 1'b1);
    @(posedge sys_clk) lv <= 10'h000;
    i_plc_cpu_model.rd(A0 + 16'h0001, d);
    chk(d, plc_mbx_pkg::PR_STANDBY);
    i_plc_cpu_model.rd(16'h0100, d);
    chk(d, 16'h0000);
    i_plc_cpu_model.wr(A0 + 16'h0002, 16'h0001);
    i_plc_cpu_model.rd(A0 + 16'h0002, d);
    chk(d, 16'h0001);
    // Callback: connecting, certificating, connected, ended
    i_plc_cpu_model.wr(A0, plc_mbx_pkg::CMD_CALLBACK);
    i_plc_cpu_model.rd(A0 + 16'h0001, d);
    chk(d, plc_mbx_pkg::PR_CONNING);
    chk(run, 1'b1);
    pulse(7'h01);
    i_plc_cpu_model.rd(A0 + 16'h0001, d);
    chk(d, plc_mbx_pkg::PR_CERT);
    pulse(7'h02);
    i_plc_cpu_model.rd(A0 + 16'h0001, d);
    chk(d, plc_mbx_pkg::PR_UP);
    i_plc_cpu_model.wr(A0, plc_mbx_pkg::CMD_NONE);
    i_plc_cpu_model.rd(A0 + 16'h0001, d);
    chk(d, plc_mbx_pkg::PR_ENDED);
    chk(run, 1'b0);
    // Failed and refused calls
    for (k = 0; k < 2; k++)
    begin
      i_plc_cpu_model.wr(A0, plc_mbx_pkg::CMD_CALLBACK);
      pulse(k == 0 ? 7'h04 : 7'h08);
      i_plc_cpu_model.rd(A0 + 16'h0001, d);
      chk(d, k == 0 ? plc_mbx_pkg::PR_FAILED : plc_mbx_pkg::PR_REFUSED);
      chk(run, 1'b0);
      i_plc_cpu_model.wr(A0, plc_mbx_pkg::CMD_NONE);
    end
    // Restart holds 16 cycles, factory restore 64, then the command clears
    for (k = 0; k < 2; k++)
    begin
      i_plc_cpu_model.wr(A0, k == 0 ? plc_mbx_pkg::CMD_RESTART : plc_mbx_pkg::CMD_FACTORY);
      @(negedge sys_clk);
      r0 = (k == 0) ? rst_o : fac_o;
      for (n = 0; n < 100 && r0 === 1'b1; n++)
      begin
        @(negedge sys_clk);
        r0 = (k == 0) ? rst_o : fac_o;
      end
      chk(16'(n), k == 0 ? 16'h0010 : 16'h0040);
      i_plc_cpu_model.rd(A0, d);
      chk(d, plc_mbx_pkg::CMD_NONE);
    end
    // Sync load; daylight shifts hour 23 round to 0
    @(posedge sys_clk) {t_sec, t_min, t_hour, t_day} <= {6'd10, 6'd30, 5'd23, 5'd31};
    i_plc_cpu_model.rd(A0 + 16'h000A, c0);
    pulse(7'h10);
    i_plc_cpu_model.rd(A0 + 16'h0003, d);
    chk(16'(d === 16'h000A || d === 16'h000B), 16'h0001);
    i_plc_cpu_model.rd(A0 + 16'h0004, d);
    chk(d, 16'h001E);
    i_plc_cpu_model.rd(A0 + 16'h0005, d);
    chk(d, 16'h0000);
    i_plc_cpu_model.rd(A0 + 16'h0006, d);
    chk(d, 16'h001F);
    // Standard time shows the hour unshifted
    i_plc_cpu_model.wr(A0 + 16'h0002, 16'h0000);
    i_plc_cpu_model.rd(A0 + 16'h0005, d);
    chk(d, 16'h0017);
    i_plc_cpu_model.rd(A0 + 16'h000A, d);
    chk(d, c0 + 16'h0001);
    for (n = 0; n < 12100 && req_o !== 1'b1; n++) @(negedge sys_clk);
    tmo(n, 12100);
    @(negedge sys_clk);
    chk(req_o, 1'b0);
    // Next request after 600 shortened seconds of 20 cycles each
    for (n = 0; n < 12100 && req_o !== 1'b1; n++) @(negedge sys_clk);
    chk(16'(n), 16'(plc_mbx_pkg::REFRESH_S * 20 - 1));
    // Indicators and jumpers; boot mode stays latched
    @(posedge sys_clk) lv <= 10'h017;
    repeat (2) @(negedge sys_clk);
    chk({led_e, led_3, led_4, pw_o, boot_o}, 5'h1F);
    @(posedge sys_clk) lv <= 10'h000;
    repeat (2) @(negedge sys_clk);
    chk({led_e, led_3, led_4, pw_o, boot_o}, 5'h01);
    r0 = led_r;
    for (n = 0; n < 20 && led_r === r0; n++) @(negedge sys_clk);
    tmo(n, 20);
    r0 = led_r;
    for (n = 0; n < 20 && led_r === r0; n++) @(negedge sys_clk);
    chk(16'(n), 16'h0008);
    // Eight server slots, the ninth refused; mode 0 takes none
    @(posedge sys_clk) lv <= 10'h020;
    for (k = 0; k < 9; k++)
    begin
      pulse(7'h20);
      chk({acc, rej}, k < 8 ? 2'b10 : 2'b01);
    end
    chk(cnt, 4'h8);
    @(posedge sys_clk) lv <= 10'h060;
    pulse(7'h20);
    chk({acc, cnt}, 5'h18);
    pulse(7'h40);
    chk(cnt, 4'h7);
    // Proprietary client turns both Modbus roles off
    @(posedge sys_clk) lv <= 10'h300;
    repeat (2) @(negedge sys_clk);
    chk({mbs_o, mbc_o}, 2'b11);
    @(posedge sys_clk) lv <= 10'h380;
    repeat (2) @(negedge sys_clk);
    chk({mbs_o, mbc_o}, 2'b00);
    report_and_stop();
  end
endmodule : plc_module_command_mailbox_tb
`default_nettype wire
